/* File: rtl/mte_pkg.sv */
package mte_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned CH_MAX  = 16;  // Channels addressable by the scan stream
	localparam int unsigned CH_W    = 4;   // Channel number width
	localparam int unsigned SMP_W   = 16;  // Signed sample width
	localparam int unsigned ADDR_W  = 8;   // Register address width
	localparam int unsigned DATA_W  = 32;  // Register data width

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL    = 8'h00;  // [0] config done, [1] AND mode
	localparam logic [7:0] REG_CHEN    = 8'h04;  // Trigger channel enable mask
	localparam logic [7:0] REG_STATUS  = 8'h08;  // [1:0] state, [2] acq ready
	localparam logic [7:0] REG_CHVALID = 8'h0C;  // Per-channel valid flags
	localparam logic [1:0] BANK_TYPE   = 2'h1;   // 0x40 + 4*ch : trigger type
	localparam logic [1:0] BANK_THR    = 2'h2;   // 0x80 + 4*ch : threshold
	localparam logic [1:0] BANK_HYST   = 2'h3;   // 0xC0 + 4*ch : hysteresis limit

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_CFG_BIT = 0;
	localparam int unsigned CTRL_AND_BIT = 1;
	localparam int unsigned STAT_RDY_BIT = 2;
	localparam logic [SMP_W-1:0]  THR_RST  = 16'h0000;
	localparam logic [SMP_W-1:0]  HYST_RST = 16'h0000;
	localparam logic [CH_MAX-1:0] CHEN_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	// Order gives code bit0 = below/falling, bit1 = latched, bit2 = edge init
	typedef enum logic [2:0] {
		TT_ABOVE,
		TT_BELOW,
		TT_ABOVE_LATCH,
		TT_BELOW_LATCH,
		TT_RISE,
		TT_FALL,
		TT_RISE_LATCH,
		TT_FALL_LATCH
	} mte_type_e;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_ACQ,
		ST_REARM
	} mte_state_e;

	// One converted sample of a scan
	typedef struct packed {
		logic                    valid;
		logic                    last;  // Final sample of the scan
		logic [CH_W-1:0]         ch;
		logic signed [SMP_W-1:0] data;
	} mte_sample_s;

	// Register port request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} mte_reg_req_s;

endpackage : mte_pkg

/* File: rtl/mte_trigger.sv */
`timescale 1ns/1ns

// Functional notes
// - Rising hysteresis trigger fires above threshold only after dropping below band.
// - Dip inside the band then rising again gives no new trigger.
// - Each scanned channel sample is judged separately for validity.
// - At scan end, combine channels: OR needs any, AND needs all.
// - Slope selects valid above threshold or below it.
// - Instantaneous channels are valid only while the condition holds.
// - OR mode starts on first valid channel; later invalidation irrelevant.
// - Level init becomes valid at or past threshold, even at start.
// - Eight comparison types: four level kinds and four edge kinds.
// - Above-level valid while above level, invalid once below.
// - Below-level valid while below level, invalid once above.
// - Above-level-latch sets valid above threshold, holds until rearm.
// - Below-level-latch sets valid below threshold, holds until rearm.
// - AND mode waits for all channels valid within the same scan.
// - Channels may use different comparison types together.
// - Rising edge drops invalid below band, then may become valid again.
// - Falling edge primed above band, valid below threshold, invalid above band.
// - OR mode triggers when condition first met and acquisition side ready.
// - AND mode triggers on a single valid channel only when it is the sole enabled one.
// - Triggers while unconfigured or acquisition busy are silently discarded.
// - Rising-edge-latch validates like rising edge, then holds until rearm.
// - Falling-edge-latch validates like falling edge, then holds until rearm.
module mte_trigger
	import mte_pkg::*;
#(
	parameter int unsigned NUM_CH = CH_MAX
) (
	input  wire logic               clock_i,
	input  wire logic               rst_i,
	input  wire mte_reg_req_s       reg_req_i,
	output logic [DATA_W-1:0]       reg_rdata_o,
	input  wire mte_sample_s        sample_i,
	input  wire logic               acq_ready_i,
	input  wire logic               acq_done_i,
	input  wire logic               rearm_i,
	output logic                    trig_o,
	output logic                    armed_o
);

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed {
		mte_state_e                           state;
		logic                                 cfg_done;
		logic                                 and_mode;
		logic [NUM_CH-1:0]                    chen;
		logic [NUM_CH-1:0][2:0]               ctype;
		logic [NUM_CH-1:0][SMP_W-1:0]         thr;
		logic [NUM_CH-1:0][SMP_W-1:0]         hyst;
		logic [NUM_CH-1:0]                    valid;
		logic [NUM_CH-1:0]                    primed;
		logic                                 trig;
		logic [DATA_W-1:0]                    rdata;
	} mte_regs_s;

	mte_regs_s state_ff;
	mte_regs_s nxt_state;

	// Register bus decode helpers
	logic [1:0]      bank;
	logic [CH_W-1:0] idx;
	logic            idx_ok;
	assign bank   = reg_req_i.addr[7:6];
	assign idx    = reg_req_i.addr[5:2];
	assign idx_ok = (32'(idx) < NUM_CH);

	// Per-sample comparison helpers
	logic                    ch_ok;
	logic signed [SMP_W-1:0] s_thr;
	logic signed [SMP_W-1:0] s_hyst;
	logic                    at_or_above;
	logic                    at_or_below;
	logic                    under_band;
	logic                    over_band;
	assign ch_ok       = (32'(sample_i.ch) < NUM_CH);
	assign s_thr       = ch_ok ? state_ff.thr[sample_i.ch] : THR_RST;
	assign s_hyst      = ch_ok ? state_ff.hyst[sample_i.ch] : HYST_RST;
	assign at_or_above = (sample_i.data >= s_thr);
	assign at_or_below = (sample_i.data <= s_thr);
	assign under_band  = (sample_i.data < s_hyst);
	assign over_band   = (sample_i.data > s_hyst);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Whole block state is computed here and registered below in one step
	always_comb begin
		logic [NUM_CH-1:0] nv;
		logic [NUM_CH-1:0] np;
		logic [NUM_CH-1:0] qual;
		logic              v;
		logic              p;
		logic              any_ok;
		logic              all_ok;
		logic              hit;
		nv        = state_ff.valid;
		np        = state_ff.primed;
		qual      = '0;
		v         = 1'b0;
		p         = 1'b0;
		any_ok    = 1'b0;
		all_ok    = 1'b0;
		hit       = 1'b0;
		nxt_state = state_ff;
		nxt_state.trig  = 1'b0;
		nxt_state.rdata = '0;

		// Register writes
		if (reg_req_i.wr) begin
			if (reg_req_i.addr == REG_CTRL) begin
				nxt_state.cfg_done = reg_req_i.wdata[CTRL_CFG_BIT];
				nxt_state.and_mode = reg_req_i.wdata[CTRL_AND_BIT];
			end else if (reg_req_i.addr == REG_CHEN) begin
				nxt_state.chen = reg_req_i.wdata[NUM_CH-1:0];
			end else if (idx_ok && bank == BANK_TYPE) begin
				nxt_state.ctype[idx] = reg_req_i.wdata[2:0];
			end else if (idx_ok && bank == BANK_THR) begin
				nxt_state.thr[idx] = reg_req_i.wdata[SMP_W-1:0];
			end else if (idx_ok && bank == BANK_HYST) begin
				nxt_state.hyst[idx] = reg_req_i.wdata[SMP_W-1:0];
			end
		end

		// Register reads, answered in the following cycle
		if (reg_req_i.rd) begin
			if (reg_req_i.addr == REG_CTRL) begin
				nxt_state.rdata[CTRL_CFG_BIT] = state_ff.cfg_done;
				nxt_state.rdata[CTRL_AND_BIT] = state_ff.and_mode;
			end else if (reg_req_i.addr == REG_CHEN) begin
				nxt_state.rdata[NUM_CH-1:0] = state_ff.chen;
			end else if (reg_req_i.addr == REG_STATUS) begin
				nxt_state.rdata[1:0]          = state_ff.state;
				nxt_state.rdata[STAT_RDY_BIT] = acq_ready_i;
			end else if (reg_req_i.addr == REG_CHVALID) begin
				nxt_state.rdata[NUM_CH-1:0] = state_ff.valid;
			end else if (idx_ok && bank == BANK_TYPE) begin
				nxt_state.rdata[2:0] = state_ff.ctype[idx];
			end else if (idx_ok && bank == BANK_THR) begin
				nxt_state.rdata[SMP_W-1:0] = state_ff.thr[idx];
			end else if (idx_ok && bank == BANK_HYST) begin
				nxt_state.rdata[SMP_W-1:0] = state_ff.hyst[idx];
			end
		end

		// judge the arriving channel on its own
		if (state_ff.state == ST_ARMED && sample_i.valid && ch_ok) begin
			v = state_ff.valid[sample_i.ch];
			p = state_ff.primed[sample_i.ch];
			unique case (mte_type_e'(state_ff.ctype[sample_i.ch]))
				TT_ABOVE: begin
					v = at_or_above;
				end
				TT_BELOW: begin
					v = at_or_below;
				end
				TT_ABOVE_LATCH: begin
					v = v | at_or_above;
				end
				TT_BELOW_LATCH: begin
					v = v | at_or_below;
				end
				TT_RISE: begin
					if (under_band) begin
						v = 1'b0;
						p = 1'b1;
					end else if (p && at_or_above) begin
						v = 1'b1;
						p = 1'b0;
					end
				end
				TT_FALL: begin
					if (over_band) begin
						v = 1'b0;
						p = 1'b1;
					end else if (p && at_or_below) begin
						v = 1'b1;
						p = 1'b0;
					end
				end
				TT_RISE_LATCH: begin
					if (!v && under_band) begin
						p = 1'b1;
					end else if (!v && p && at_or_above) begin
						v = 1'b1;
						p = 1'b0;
					end
				end
				TT_FALL_LATCH: begin
					if (!v && over_band) begin
						p = 1'b1;
					end else if (!v && p && at_or_below) begin
						v = 1'b1;
						p = 1'b0;
					end
				end
			endcase
			// slope and edge priming chosen by type above
			nv[sample_i.ch] = v;
			np[sample_i.ch] = p;
			nxt_state.valid  = nv;
			nxt_state.primed = np;
		end

		// combine at the end of each scan
		qual   = nv & state_ff.chen;
		any_ok = |qual;
		// every enabled channel valid in this scan
		all_ok = (state_ff.chen != '0) && (qual == state_ff.chen);
		hit    = state_ff.and_mode ? all_ok : any_ok;

		// Acquisition sequencing
		unique case (state_ff.state)
			ST_IDLE: begin
				if (state_ff.cfg_done) begin
					nxt_state.state = ST_ARMED;
				end
			end
			ST_ARMED: begin
				// fire on first qualifying scan when ready
				if (sample_i.valid && sample_i.last && hit && acq_ready_i) begin
					nxt_state.trig  = 1'b1;
					nxt_state.state = ST_ACQ;
				end
			end
			ST_ACQ: begin
				if (acq_done_i) begin
					nxt_state.state = ST_REARM;
				end
			end
			ST_REARM: begin
				if (rearm_i) begin
					nxt_state.valid  = '0;
					nxt_state.primed = '0;
					nxt_state.state  = ST_ARMED;
				end
			end
		endcase

		// no configuration means no evaluation, nothing reported
		if (!state_ff.cfg_done) begin
			nxt_state.state  = ST_IDLE;
			nxt_state.valid  = '0;
			nxt_state.primed = '0;
			nxt_state.trig   = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Reset leaves every channel above-level with zero levels, all disabled
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_ff          <= '0;
			state_ff.state    <= ST_IDLE;
			state_ff.chen     <= CHEN_RST[NUM_CH-1:0];
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata_o = state_ff.rdata;
	assign trig_o      = state_ff.trig;  // One-cycle pulse
	assign armed_o     = (state_ff.state == ST_ARMED);

endmodule : mte_trigger

/* File: verif/mte_acq_model.sv */
`timescale 1ns/1ns
module mte_acq_model (
	input  wire logic clock_i,
	input  wire logic rst_i,
	input  wire logic ready_en_i,
	input  wire logic trig_i,
	output logic      acq_ready_o,
	output logic      acq_done_o,
	output logic      rearm_o
);
	logic [3:0] cnt_ff;
	// Busy after a trigger, so ready stays low until the cycle after the re-arm pulse
	always_ff @(posedge clock_i) begin
		if (rst_i)
			cnt_ff <= 4'h0;
		else if (trig_i)
			cnt_ff <= 4'h6;
		else if (cnt_ff != 4'h0)
			cnt_ff <= cnt_ff - 4'h1;
	end
	// Completion first, re-arm two cycles later
	assign acq_ready_o = ready_en_i && (cnt_ff == 4'h0);
	assign acq_done_o  = (cnt_ff == 4'h3);
	assign rearm_o     = (cnt_ff == 4'h1);
endmodule : mte_acq_model

/* File: verif/mte_trigger_monitor.sv */
`timescale 1ns/1ns
module mte_trigger_monitor
	import mte_pkg::*;
(
	input wire logic              clock_i,
	input wire logic              rst_i,
	input wire mte_reg_req_s      reg_req_i,
	input wire logic [DATA_W-1:0] reg_rdata_o,
	input wire mte_sample_s       sample_i,
	input wire logic              acq_ready_i,
	input wire logic              rearm_i,
	input wire logic              trig_o,
	input wire logic              armed_o
);
	// ------
	// Checks
	// ------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	logic scan_end;
	// Last sample of a scan taken while evaluating
	assign scan_end = armed_o && sample_i.valid && sample_i.last;
	a_trig_pulse: assert property (trig_o |=> !trig_o [*2])
		else $error("trigger not a single pulse");
	a_trig_disarm: assert property (trig_o |-> !armed_o ##1 !armed_o)
		else $error("still armed after trigger");
	a_trig_cause: assert property (trig_o |-> $past(scan_end && acq_ready_i))
		else $error("trigger without ready scan end");
	a_busy_drop: assert property (scan_end && !acq_ready_i |=> !trig_o)
		else $error("trigger while acquisition busy");
	a_idle_quiet: assert property (!armed_o |=> !trig_o)
		else $error("trigger while not armed");
	a_arm_cause: assert property ($rose(armed_o) |->
		$past(rearm_i) || $past(reg_req_i.wr, 2) || $past(reg_req_i.wr, 3))
		else $error("armed without rearm or setup");
	a_status_view: assert property ($past(reg_req_i.rd && reg_req_i.addr == REG_STATUS)
		|-> reg_rdata_o[STAT_RDY_BIT] == $past(acq_ready_i)
		&& (reg_rdata_o[1:0] == 2'h1) == $past(armed_o))
		else $error("status read wrong");
	a_rdata_idle: assert property (!$past(reg_req_i.rd) |-> reg_rdata_o == '0)
		else $error("read data outside read slot");
endmodule : mte_trigger_monitor

bind mte_trigger mte_trigger_monitor i_mon (.clock_i(clock_i), .rst_i(rst_i),
	.reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .sample_i(sample_i),
	.acq_ready_i(acq_ready_i), .rearm_i(rearm_i), .trig_o(trig_o), .armed_o(armed_o));

/* File: verif/mte_trigger_tb.sv */
`timescale 1ns/1ns
module mte_trigger_tb
	import mte_pkg::*;
;
	logic              clock_i  = 1'b0;
	logic              rst_i    = 1'b1;
	mte_reg_req_s      req      = '0;
	mte_sample_s       smp      = '0;
	logic              ready_en = 1'b1;
	logic [DATA_W-1:0] rdata;
	logic              acq_ready, acq_done, rearm, trig, armed;
	int                fail_count = 0;
	int                n_tests    = 0;
	// Valid pattern per sample for above, above-latch, rise, rise-latch
	localparam logic [4:0]  PAT [4] = '{5'h05, 5'h1F, 5'h0C, 5'h1C};
	localparam logic [15:0] SEQ [5] = '{16'h0032, 16'hFF38, 16'h0032, 16'hFFCE, 16'hFF38};

	always #20 clock_i = ~clock_i;

	mte_trigger i_dut (.clock_i(clock_i), .rst_i(rst_i), .reg_req_i(req),
		.reg_rdata_o(rdata), .sample_i(smp), .acq_ready_i(acq_ready),
		.acq_done_i(acq_done), .rearm_i(rearm), .trig_o(trig), .armed_o(armed));
	mte_acq_model i_acq (.clock_i(clock_i), .rst_i(rst_i), .ready_en_i(ready_en),
		.trig_i(trig), .acq_ready_o(acq_ready), .acq_done_o(acq_done), .rearm_o(rearm));

	// -----
	// Tasks
	// -----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i) req <= '{1'b1, 1'b0, a, d};
		@(posedge clock_i) req <= '0;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock_i) req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clock_i) req <= '0;
		@(negedge clock_i) chk(rdata, e);
	endtask : rd
	task automatic send(input logic [3:0] c, input logic [15:0] d, input logic l);
		@(posedge clock_i) smp <= '{1'b1, l, c, d};
	endtask : send
	// Closing sample of a scan, then the one-cycle trigger slot
	task automatic scan(input logic [3:0] c, input logic [15:0] d, input logic e);
		send(c, d, 1'b1);
		@(posedge clock_i) smp <= '0;
		@(negedge clock_i) chk({31'h0, trig}, {31'h0, e});
	endtask : scan
	task automatic arm();
		int i;
		for (i = 0; i < 20 && armed !== 1'b1; i++)
			@(negedge clock_i);
		chk({31'h0, armed}, 32'h1);
	endtask : arm
	task automatic cfg(input logic [3:0] c, input logic [2:0] t, input logic [15:0] th,
		input logic [15:0] hy);
		wr({BANK_TYPE, c, 2'h0}, {29'h0, t});
		wr({BANK_THR, c, 2'h0}, {16'h0, th});
		wr({BANK_HYST, c, 2'h0}, {16'h0, hy});
	endtask : cfg
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	// ---------
	// Sequence
	// ---------
	initial begin
		int t;
		int k;
		logic [15:0] v;
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		rd(REG_CTRL, 32'h0);
		rd(REG_STATUS, 32'h4);
		wr(8'h10, 32'hFFFF);
		rd(8'h10, 32'h0);
		// OR mode, one rising channel with band below threshold
		cfg(4'h0, TT_RISE, 16'h0064, 16'hFF9C);
		rd({BANK_THR, 4'h0, 2'h0}, 32'h0064);
		wr(REG_CHEN, 32'h1);
		wr(REG_CTRL, 32'h1);
		arm();
		scan(4'h0, 16'h00C8, 1'b0);
		scan(4'h0, 16'hFF38, 1'b0);
		scan(4'h0, 16'h0032, 1'b0);
		scan(4'h0, 16'h00C8, 1'b1);
		arm();
		scan(4'h0, 16'h00C8, 1'b0);
		@(posedge clock_i) ready_en <= 1'b0;
		scan(4'h0, 16'hFF38, 1'b0);
		scan(4'h0, 16'h00C8, 1'b0);
		scan(4'h0, 16'h0032, 1'b0);
		rd(REG_CHVALID, 32'h1);
		scan(4'h0, 16'hFF38, 1'b0);
		rd(REG_CHVALID, 32'h0);
		@(posedge clock_i) ready_en <= 1'b1;
		// Every type on one channel; falling kinds see the mirrored samples
		for (t = 0; t < 8; t++) begin
			wr(REG_CTRL, 32'h0);
			cfg(4'h1, 3'(t), 16'h0000, t[0] ? 16'h0064 : 16'hFF9C);
			wr(REG_CHEN, 32'h6);
			wr(REG_CTRL, 32'h3);
			arm();
			for (k = 0; k < 5; k++) begin
				v = SEQ[k];
				scan(4'h1, t[0] ? -v : v, 1'b0);
				rd(REG_CHVALID, {30'h0, PAT[t[2:1]][k], 1'b0});
			end
		end
		// AND mode mixing a latched and an instantaneous channel
		wr(REG_CTRL, 32'h0);
		cfg(4'h0, TT_ABOVE_LATCH, 16'h0064, 16'h0000);
		cfg(4'h1, TT_BELOW, 16'h0000, 16'h0000);
		wr(REG_CHEN, 32'h3);
		// A qualifying scan while configuration is incomplete must be ignored
		send(4'h0, 16'h00C8, 1'b0);
		scan(4'h1, 16'hFFCE, 1'b0);
		rd(REG_CHVALID, 32'h0);
		wr(REG_CTRL, 32'h3);
		arm();
		send(4'h0, 16'h00C8, 1'b0);
		scan(4'h1, 16'h0032, 1'b0);
		send(4'h0, 16'hFED4, 1'b0);
		scan(4'h1, 16'hFFCE, 1'b1);
		arm();
		rd(REG_CHVALID, 32'h0);
		close_out();
	end

	// Hang guard well beyond the expected run length
	initial begin
		#400000;
		fail_count++;
		close_out();
	end
endmodule : mte_trigger_tb
